// ### src/aclsh_pkg.sv
// Purpose: Shared constants and state types of the audio link slot handler
// Assumes: Bit clock and serial input arrive from the codec, outside mclk_in's domain
// Notes:   Register offsets are word indexes on the plain register port
package aclsh_pkg;

    // ==========================================================
    // Frame geometry
    localparam logic [4:0] TAG_LEFT    = 5'h0F;
    localparam logic [4:0] SLOT_LEFT   = 5'h13;
    localparam logic [3:0] LAST_SLOT   = 4'hC;
    localparam logic [3:0] FIRST_TX    = 4'h6;
    localparam int         TX_SLOTS    = 7;
    localparam logic [5:0] MARKER_BITS = 6'h10;
    localparam logic [8:0] FRAME_BITS  = 9'h100;

    // ==========================================================
    // Register offsets and fields
    localparam logic [3:0] REG_CTRL  = 4'h0;
    localparam logic [3:0] REG_STAT  = 4'h1;
    localparam logic [3:0] REG_MASK  = 4'h2;
    localparam logic [3:0] REG_INFO  = 4'h3;
    localparam logic [3:0] REG_DIS   = 4'h4;
    localparam int         CTRL_LINK = 0;
    localparam int         CTRL_TX   = 1;
    localparam int         CTRL_RX   = 2;
    localparam int         CTRL_RES  = 3;
    localparam int         CTRL_DBL  = 5;
    localparam int         ST_FRAME  = 0;
    localparam int         ST_UNDER  = 1;
    localparam int         ST_ECHO   = 2;
    localparam int         ST_READY  = 3;

    // Sample resolution codes and the masks that zero the unused low bits
    localparam logic [1:0]  RES20  = 2'h0;
    localparam logic [1:0]  RES18  = 2'h1;
    localparam logic [1:0]  RES16  = 2'h2;
    localparam logic [19:0] MASK20 = 20'hFFFFF;
    localparam logic [19:0] MASK18 = 20'hFFFFC;
    localparam logic [19:0] MASK16 = 20'hFFFF0;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } aclsh_sync_s;

    typedef struct packed {
        logic             bclk_q;
        logic [3:0]       slot;
        logic [4:0]       left;
        logic             marker;
        logic             sout;
        logic             fstart;
        logic [15:0]      tag_o;
        logic [6:0][19:0] txd;
        logic [6:0]       pop;
        logic [19:0]      sh;
        logic             ready;
        logic [12:1]      in_valid;
        logic [6:0]       echo;
        logic [9:0]       dis_pend;
        logic [9:0]       dis;
        logic             rx_stb;
        logic [3:0]       rx_slot;
        logic [19:0]      rx_data;
        logic [7:0]       ctrl;
        logic [3:0]       stat;
        logic [3:0]       mask;
        logic [31:0]      rdata;
        logic             irq;
    } aclsh_state_s;

endpackage

// ### src/aclsh_sync.sv
// Purpose: Two-flop synchroniser for the codec bit clock and serial input
// Assumes: Both inputs come from outside the mclk_in domain
// Notes:   Bit 0 carries the bit clock, bit 1 the serial data
module aclsh_sync import aclsh_pkg::*; (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire logic [1:0] async_in,
    output logic      [1:0] sync_out
);

    aclsh_sync_s st_r;
    aclsh_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;

endmodule

// ### src/aclsh_slot_handler.sv
// Purpose: Frame slot logic of the audio codec link controller
// Assumes: Codec drives codec_bit_clock_in; both link inputs are synchronised here
// Notes:   Output slots 1 to 5 and input slot data beyond the strobe are handled elsewhere

// What this block does
// - Slots 6 to 9 carry centre, surround and effects samples, 20 bits each.
// - Narrow playback samples in slots 6 to 9 get zero low-order bits.
// - Slot 10 carries modem line 2 data or extra left double-rate sample.
// - Slot 11 carries modem handset data or extra right double-rate sample.
// - Slot 12 carries modem GPIO control or extra centre double-rate sample.
// - Incoming serial data is sampled on the falling bit clock edge.
// - Incoming tag bit 15 shows codec readiness; polled before normal use.
// - Incoming tag bits 14 to 3 flag slots 1 to 12; 2:0 reserved.
// - Slot-valid flags of each incoming tag are kept for that frame.
// - Received data of slots 2 to 12 is stored only while receive accept is set.
// - Marker falls on the rise that sends the last tag bit; later slots hold 20 bits.
// - Empty transmit source flags underflow and sends zeros, marked invalid.
// - Slot 1 bits 11:2 disable slots 3 to 12 in the next frame.
// - Marker high for 16 bit clocks per frame; output launched on rises.
// - Outgoing tag built from data validity, enables and disable requests.
module aclsh_slot_handler import aclsh_pkg::*; (
    input  wire logic             mclk_in,
    input  wire logic             resetn_in,
    input  wire logic             codec_bit_clock_in,
    input  wire logic             serial_in_line_in,
    output logic                  frame_marker_out,
    output logic                  serial_out_line_out,
    input  wire logic [6:0][19:0] tx_slot_data_in,
    input  wire logic [6:0]       tx_slot_ready_in,
    output logic      [6:0]       tx_slot_pop_out,
    output logic                  rx_strobe_out,
    output logic      [3:0]       rx_slot_out,
    output logic      [19:0]      rx_data_out,
    input  wire logic [3:0]       reg_addr_in,
    input  wire logic [31:0]      reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic      [31:0]      reg_rdata_out,
    output logic                  irq_out
);

    aclsh_state_s st_r;
    aclsh_state_s st_nxt;
    logic [1:0]   link_s;
    logic         rise;
    logic         fall;
    logic [3:0]   ev;

    aclsh_sync u_sync (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .async_in  ({serial_in_line_in, codec_bit_clock_in}),
        .sync_out  (link_s)
    );

    assign rise = link_s[0] && !st_r.bclk_q;
    assign fall = !link_s[0] && st_r.bclk_q;

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [3:0]  ns;
        logic [4:0]  nl;
        logic [19:0] w;
        logic [19:0] rm;
        ns          = st_r.slot;
        nl          = st_r.left;
        rm          = MASK20;
        w           = {st_r.sh[18:0], link_s[1]};
        st_nxt      = st_r;
        st_nxt.bclk_q = link_s[0];
        st_nxt.pop  = '0;
        st_nxt.rx_stb = 1'b0;
        st_nxt.fstart = 1'b0;
        ev          = '0;
        case (st_r.ctrl[CTRL_RES +: 2])
            RES18:   rm = MASK18;
            RES16:   rm = MASK16;
            default: rm = MASK20;
        endcase
        if (!st_r.ctrl[CTRL_LINK]) begin
            // Park one bit before the end so the first rise raises the marker
            st_nxt.slot   = LAST_SLOT;
            st_nxt.left   = 5'h01;
            st_nxt.marker = 1'b0;
            st_nxt.sout   = 1'b0;
        end else begin
            if (rise) begin
                if (st_r.left == '0) begin
                    ns = (st_r.slot == LAST_SLOT) ? 4'h0 : st_r.slot + 4'h1;
                    nl = (ns == 4'h0) ? TAG_LEFT : SLOT_LEFT;
                end else begin
                    nl = st_r.left - 5'h01;
                end
                st_nxt.slot = ns;
                st_nxt.left = nl;
                st_nxt.marker = (ns == 4'h0 && nl != '0) || (ns == LAST_SLOT && nl == '0);
                if (ns == 4'h0 && nl == TAG_LEFT) begin
                    st_nxt.fstart = 1'b1;
                    ev[ST_FRAME]  = 1'b1;
                    st_nxt.dis    = st_r.dis_pend;
                    st_nxt.tag_o  = '0;
                    for (int i = 0; i < TX_SLOTS; i++) begin
                        if (st_r.ctrl[CTRL_TX] && !st_r.dis_pend[6 - i]) begin
                            if (tx_slot_ready_in[i]) begin
                                st_nxt.pop[i]       = 1'b1;
                                st_nxt.tag_o[9 - i] = 1'b1;
                                if (i < 4 || st_r.ctrl[CTRL_DBL]) begin
                                    st_nxt.txd[i] = tx_slot_data_in[i] & rm;
                                end else if (i == 6) begin
                                    st_nxt.txd[i] = tx_slot_data_in[i];
                                end else begin
                                    st_nxt.txd[i] = tx_slot_data_in[i] & MASK16;
                                end
                            end else begin
                                st_nxt.txd[i] = '0;
                                ev[ST_UNDER]  = 1'b1;
                            end
                        end else begin
                            st_nxt.txd[i] = '0;
                        end
                    end
                    st_nxt.tag_o[15] = |st_nxt.pop;
                end
                if (ns == 4'h0) begin
                    st_nxt.sout = st_nxt.tag_o[nl[3:0]];
                end else if (ns >= FIRST_TX) begin
                    st_nxt.sout = st_nxt.txd[3'(ns - FIRST_TX)][nl];
                end else begin
                    st_nxt.sout = 1'b0;
                end
            end
            if (fall) begin
                st_nxt.sh = w;
                if (st_r.left == '0) begin
                    case (st_r.slot)
                        4'h0: begin
                            st_nxt.ready    = w[15];
                            st_nxt.in_valid = {<<{w[14:3]}};
                            ev[ST_READY]    = w[15] && !st_r.ready;
                        end
                        4'h1: begin
                            st_nxt.dis_pend = w[11:2];
                            if (st_r.in_valid[1]) begin
                                st_nxt.echo  = w[18:12];
                                ev[ST_ECHO]  = 1'b1;
                            end
                        end
                        default: begin
                            if (st_r.in_valid[st_r.slot] && st_r.ctrl[CTRL_RX]) begin
                                st_nxt.rx_stb  = 1'b1;
                                st_nxt.rx_slot = st_r.slot;
                                st_nxt.rx_data = w;
                            end
                        end
                    endcase
                end
            end
        end
        // Register port
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL: st_nxt.ctrl = reg_wdata_in[7:0];
                REG_MASK: st_nxt.mask = reg_wdata_in[3:0];
                default:  ;
            endcase
        end
        st_nxt.rdata = '0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
                REG_STAT: st_nxt.rdata = {28'h0000000, st_r.stat};
                REG_MASK: st_nxt.rdata = {28'h0000000, st_r.mask};
                REG_INFO: st_nxt.rdata = {12'h000, st_r.echo, st_r.in_valid, st_r.ready};
                REG_DIS:  st_nxt.rdata = {22'h000000, st_r.dis_pend};
                default:  st_nxt.rdata = '0;
            endcase
        end
        // Events win over the clear-on-read
        st_nxt.stat = ((reg_rd_in && reg_addr_in == REG_STAT) ? 4'h0 : st_r.stat) | ev;
        st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            st_r      <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.stat <= STAT_RST;
            st_r.mask <= MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign frame_marker_out    = st_r.marker;
    assign serial_out_line_out = st_r.sout;
    assign tx_slot_pop_out     = st_r.pop;
    assign rx_strobe_out       = st_r.rx_stb;
    assign rx_slot_out         = st_r.rx_slot;
    assign rx_data_out         = st_r.rx_data;
    assign reg_rdata_out       = st_r.rdata;
    assign irq_out             = st_r.irq;

    // ==========================================================
    // Checks
    logic [5:0] mk_cnt;
    logic [8:0] fr_cnt;
    logic [8:0] fr_prev;
    logic       fr_seen;
    logic [6:0] nz;

    always_comb begin
        for (int i = 0; i < TX_SLOTS; i++) begin
            nz[i] = |st_r.txd[i];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in || !st_r.ctrl[CTRL_LINK]) begin
            mk_cnt  <= '0;
            fr_cnt  <= '0;
            fr_prev <= '0;
            fr_seen <= 1'b0;
        end else begin
            if (st_nxt.marker && !st_r.marker) begin
                mk_cnt <= 6'h01;
            end else if (rise && st_nxt.marker && mk_cnt != 6'h3F) begin
                mk_cnt <= mk_cnt + 6'h01;
            end
            if (st_nxt.fstart) begin
                fr_cnt  <= 9'h001;
                fr_prev <= fr_cnt;
                fr_seen <= 1'b1;
            end else if (rise && fr_cnt != 9'h1FF) begin
                fr_cnt <= fr_cnt + 9'h001;
            end
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    property p_marker_len;
        $fell(frame_marker_out) && $past(st_r.ctrl[CTRL_LINK]) |-> mk_cnt == MARKER_BITS;
    endproperty
    a_marker_len: assert property (p_marker_len) else $error("frame marker width wrong");

    property p_frame_len;
        st_r.fstart && fr_prev != 9'h001 && $past(fr_seen) |-> fr_prev == FRAME_BITS;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length not 256 bits");

    property p_tag_match;
        st_r.fstart |-> st_r.tag_o[9:3] == {<<{st_r.pop}} && st_r.tag_o[15] == |st_r.pop;
    endproperty
    a_tag_match: assert property (p_tag_match) else $error("outgoing tag disagrees with loads");

    property p_underflow_zero;
        st_r.fstart |-> (nz & ~st_r.pop) == 7'h00;
    endproperty
    a_underflow_zero: assert property (p_underflow_zero) else $error("unloaded slot not zero");

    property p_disable;
        st_r.fstart |-> (st_r.pop & {<<{st_r.dis[6:0]}}) == 7'h00;
    endproperty
    a_disable: assert property (p_disable) else $error("disabled slot was loaded");

    property p_zero_fill;
        |st_r.pop && $past(st_r.ctrl[CTRL_RES +: 2]) == RES16 |->
            st_r.txd[0][3:0] == 4'h0 && st_r.txd[3][3:0] == 4'h0;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("low bits not zero-filled");

    property p_tag_reserved;
        st_r.slot == 4'h0 && st_r.left < 5'h03 && st_r.ctrl[CTRL_LINK] |-> !serial_out_line_out;
    endproperty
    a_tag_reserved: assert property (p_tag_reserved) else $error("reserved tag bit driven high");

    property p_rx_accept;
        rx_strobe_out |-> $past(st_r.ctrl[CTRL_RX]) && $past(fall);
    endproperty
    a_rx_accept: assert property (p_rx_accept) else $error("slot stored without accept");

    property p_rx_valid;
        rx_strobe_out |-> st_r.in_valid[rx_slot_out] && rx_slot_out >= 4'h2;
    endproperty
    a_rx_valid: assert property (p_rx_valid) else $error("stored slot not tagged valid");

    property p_ready_event;
        $rose(st_r.ready) |-> st_r.stat[ST_READY];
    endproperty
    a_ready_event: assert property (p_ready_event) else $error("codec ready not flagged");

endmodule

// ### tb/aclsh_codec_model.sv
// Purpose: Behavioural codec on the far side of the audio link
// Assumes: Bit clock runs free at 160 ns; a frame starts at the first rise that sees the marker high
// Notes:   Frames are held as 256-bit vectors, bit 255 first on the wire
module aclsh_codec_model (
    input  wire logic         frame_marker_in,
    input  wire logic         serial_out_line_in,
    input  wire logic [255:0] in_frame_in,
    output logic              codec_bit_clock_out,
    output logic              serial_in_line_out,
    output logic      [255:0] out_frame_out,
    output int                frame_cnt_out,
    output int                marker_hi_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [255:0] shreg;
    logic [255:0] cap;
    logic         mk_q;
    logic         active;
    int           idx;
    int           hi;

    // ==========================================================
    // Bit clock, phase unrelated to the system clock
    initial begin
        codec_bit_clock_out = 1'b0;
        serial_in_line_out  = 1'b0;
        mk_q                = 1'b0;
        active              = 1'b0;
        idx                 = 0;
        hi                  = 0;
        frame_cnt_out       = 0;
        marker_hi_out       = 0;
        #13;
        forever #80 codec_bit_clock_out = ~codec_bit_clock_out;
    end

    // ==========================================================
    // Launch on rises; idle line toggles so a stale bit never looks valid
    // tag first, MSB first
    always @(posedge codec_bit_clock_out) begin
        if (frame_marker_in && !mk_q) begin
            idx    = 0;
            hi     = 0;
            shreg  = in_frame_in;
            active = 1'b1;
        end else begin
            idx = (idx + 1) % 256;
        end
        hi += int'(frame_marker_in);
        mk_q = frame_marker_in;
        serial_in_line_out <= active ? shreg[255 - idx] : ~serial_in_line_out;
    end

    always @(negedge codec_bit_clock_out) begin
        if (active) begin
            cap[255 - idx] = serial_out_line_in;
            if (idx == 255) begin
                out_frame_out = cap;
                marker_hi_out = hi;
                frame_cnt_out++;
            end
        end
    end
endmodule

// ### tb/aclsh_slot_handler_test.sv
// Purpose: Self-checking bench of the audio link slot handler
// Assumes: Transmit settings written mid-frame take effect at the next frame start
// Notes:   Frame A modem mode, B 16-bit double rate with a gap and a disable, C 18-bit
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module aclsh_slot_handler_test import aclsh_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic             mclk_in, resetn_in, codec_bit_clock_in, serial_in_line_in;
    logic             frame_marker_out, serial_out_line_out, rx_strobe_out, irq_out;
    logic [6:0][19:0] tx_slot_data_in;
    logic [6:0]       tx_slot_ready_in, tx_slot_pop_out;
    logic [3:0]       rx_slot_out, reg_addr_in, rx_s;
    logic [19:0]      rx_data_out, rx_d;
    logic [31:0]      reg_wdata_in, reg_rdata_out;
    logic             reg_wr_in, reg_rd_in;
    logic [255:0]     in_frame, out_frame;
    int               frame_cnt, hi_cnt, rx_n, pop_n, checks, fail_count;

    aclsh_slot_handler u_dut (
        .mclk_in, .resetn_in, .codec_bit_clock_in, .serial_in_line_in, .frame_marker_out,
        .serial_out_line_out, .tx_slot_data_in, .tx_slot_ready_in, .tx_slot_pop_out, .rx_strobe_out,
        .rx_slot_out, .rx_data_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out
    );

    aclsh_codec_model u_codec (
        .frame_marker_in(frame_marker_out), .serial_out_line_in(serial_out_line_out), .in_frame_in(in_frame),
        .codec_bit_clock_out(codec_bit_clock_in), .serial_in_line_out(serial_in_line_in),
        .out_frame_out(out_frame), .frame_cnt_out(frame_cnt), .marker_hi_out(hi_cnt)
    );

    always #5 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        pop_n += $countones(tx_slot_pop_out);
        if (rx_strobe_out === 1'b1) begin
            rx_n++;
            rx_s = rx_slot_out;
            rx_d = rx_data_out;
        end
    end

    // ==========================================================
    // Register port and frame helpers
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in   <= 1'b0;
        @(negedge mclk_in);
        `CHK(reg_rdata_out, e)
    endtask

    function automatic logic [255:0] mk_in(input logic [15:0] tag, input logic [19:0] s1, input logic [19:0] s3);
        logic [255:0] f;
        f            = '0;
        f[255 -: 16] = tag;
        f[239 -: 20] = s1;
        f[199 -: 20] = s3;
        return f;
    endfunction

    task automatic wait_frame(input int n);
        for (int i = 0; i < 6000 && frame_cnt < n; i++) @(posedge mclk_in);
        if (frame_cnt < n) fail_count++;
        // Let the next frame start reach the design's registers
        @(posedge codec_bit_clock_in);
        repeat (5) @(posedge mclk_in);
    endtask

    // Slots without a tag bit must be zero; modem slots 10 and 11 are 16 bits
    task automatic chk_frame(input logic [15:0] tag, input logic [19:0] rm, input logic dbl);
        logic [19:0] m;
        logic [19:0] e;
        `CHK(out_frame[255 -: 16], tag)
        `CHK(hi_cnt, 16)
        for (int k = 1; k <= 12; k++) begin
            m = (k <= 9 || dbl) ? rm : (k == 12 ? MASK20 : MASK16);
            e = (k >= 6 && tag[15 - k]) ? tx_slot_data_in[k - 6] & m : 20'h00000;
            `CHK(out_frame[239 - 20 * (k - 1) -: 20], e)
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #500us;
        fail_count++;
        stop_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        mclk_in          = 1'b0;
        resetn_in        = 1'b0;
        reg_wr_in        = 1'b0;
        reg_rd_in        = 1'b0;
        reg_addr_in      = 4'h0;
        reg_wdata_in     = 32'h00000000;
        tx_slot_ready_in = 7'h7F;
        in_frame         = mk_in(16'hD000, {1'b0, 7'h2A, 10'h020, 2'h0}, 20'h12345);
        for (int i = 0; i < 7; i++) tx_slot_data_in[i] = {4'(i + 1), 16'hC3F7};
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        wr(REG_INFO, 32'hFFFFFFFF);
        for (int a = 0; a < 8; a++) rd(4'(a), 32'h00000000);
        wr(REG_CTRL, 32'h00000007);
        rd(REG_CTRL, 32'h00000007);
        // Tag is taken at the bit clock fall after the marker drops
        @(negedge frame_marker_out);
        @(negedge codec_bit_clock_in);
        repeat (4) @(posedge mclk_in);
        rd(REG_STAT, 32'h00000009);
        in_frame = mk_in(16'h9000, 20'h00000, 20'h6789A);
        wr(REG_MASK, 32'h00000002);
        tx_slot_ready_in <= 7'h3F;
        wr(REG_CTRL, 32'h00000037);
        wait_frame(1);
        rd(REG_INFO, 32'h0005400B);
        chk_frame(16'h83F8, MASK20, 1'b0);
        `CHK(rx_s, 4'h3)
        `CHK(rx_d, 20'h12345)
        `CHK(irq_out, 1'b1)
        rd(REG_STAT, 32'h00000007);
        wr(REG_CTRL, 32'h0000002B);
        tx_slot_ready_in <= 7'h7F;
        `CHK(irq_out, 1'b0)
        wait_frame(2);
        chk_frame(16'h82F0, MASK16, 1'b1);
        wr(REG_CTRL, 32'h00000001);
        wait_frame(3);
        chk_frame(16'h83F8, MASK18, 1'b1);
        `CHK(pop_n, 19)
        `CHK(rx_n, 1)
        `CHK(irq_out, 1'b0)
        rd(REG_STAT, 32'h00000001);
        stop_test();
    end
endmodule
